// ### logic/epr_regs.sv
// Purpose: Routing of enable pins three and four, power-good status
// Assumes: AXI4-Lite master; OTP defaults stable while resetn is low
// Notes: Register data sits in bits 7:0, upper bits read as zero
`timescale 1ns/10ps
`default_nettype none
module epr_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // AXI4-Lite write address
    input wire logic [epr_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic [2:0] s_axil_awprot,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    // AXI4-Lite write data
    input wire logic [epr_pkg::DATA_W-1:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // AXI4-Lite read address
    input wire logic [epr_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic [2:0] s_axil_arprot,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    // AXI4-Lite read data
    output logic [epr_pkg::DATA_W-1:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // Fuse defaults
    input wire epr_pkg::epr_route_t otp_route_dflt,
    // Enable pins
    input wire logic enable_pin_three,
    input wire logic enable_pin_four,
    // Regulation comparators, bit 0 is unit 1
    input wire logic [3:0] buck_regulation_ok,
    input wire logic [3:0] ldo_regulation_ok,
    // Regulator control and interrupt
    output epr_pkg::epr_pin_ctl_t pin_ctl,
    output logic irq
);
    // ==========================================================
    // Helper functions
    function automatic logic [5:0] addr_idx(input logic [epr_pkg::ADDR_W-1:0] a);
        addr_idx = a[7:2];
    endfunction

    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx == epr_pkg::IDX_PIN3_HI) ||
                     (idx == epr_pkg::IDX_PIN4_LO) ||
                     (idx == epr_pkg::IDX_PIN4_HI) ||
                     (idx == epr_pkg::IDX_PG_STATUS) ||
                     (idx == epr_pkg::IDX_EVT_STATUS) ||
                     (idx == epr_pkg::IDX_EVT_MASK);
    endfunction

    // High route byte to {buck4..1, LDO10..1}
    function automatic logic [13:0] hi_vec(input logic [7:0] hi);
        logic [9:0] ldo;
        ldo = 10'h000;
        ldo[9] = hi[epr_pkg::HI_LDO10_BIT];
        ldo[8] = hi[epr_pkg::HI_LDO9_BIT];
        hi_vec = {hi[epr_pkg::HI_BUCK_LSB+3:epr_pkg::HI_BUCK_LSB], ldo};
    endfunction

    // ==========================================================
    // Declarations
    epr_pkg::epr_route_t route_r;
    epr_pkg::epr_route_t route_nxt;
    epr_pkg::epr_pg_t pg_sync;
    epr_pkg::epr_pg_t pg_r;
    epr_pkg::epr_pin_ctl_t pin_ctl_r;
    logic pin3_sync;
    logic pin4_sync;
    logic aw_held_r;
    logic w_held_r;
    logic [5:0] aw_idx_r;
    logic [7:0] wbyte_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [7:0] rbyte_r;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic evt_irq;
    logic irq_r;

    // ==========================================================
    // Input synchronisers
    epr_sync #(
        .W(2)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d_async({enable_pin_three, enable_pin_four}),
        .q({pin3_sync, pin4_sync})
    );

    // Comparators are analog levels, so they are synchronised too
    epr_sync #(
        .W(8)
    ) u_pg_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .d_async({ldo_regulation_ok, buck_regulation_ok}),
        .q(pg_sync)
    );

    // ==========================================================
    // Write channel decode
    wire aw_take = s_axil_awvalid && s_axil_awready;
    wire w_take = s_axil_wvalid && s_axil_wready;
    wire wr_fire = aw_held_r && w_held_r;
    wire wr_en = wr_fire && wstrb0_r;
    wire wr_pin3_hi = wr_en && (aw_idx_r == epr_pkg::IDX_PIN3_HI);
    wire wr_pin4_lo = wr_en && (aw_idx_r == epr_pkg::IDX_PIN4_LO);
    wire wr_pin4_hi = wr_en && (aw_idx_r == epr_pkg::IDX_PIN4_HI);
    wire wr_evt_mask = wr_en && (aw_idx_r == epr_pkg::IDX_EVT_MASK);
    wire [1:0] wr_resp = idx_mapped(aw_idx_r) ? epr_pkg::RESP_OKAY
                                              : epr_pkg::RESP_SLVERR;

    // Address and data wait for each other, in either order
    assign s_axil_awready = !aw_held_r && !bvalid_r;
    assign s_axil_wready = !w_held_r && !bvalid_r;
    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;

    // ==========================================================
    // Routing registers
    // Reserved bits never take write data
    assign route_nxt.pin3_hi = wr_pin3_hi ? (wbyte_r & epr_pkg::HI_WR_MASK)
                                          : route_r.pin3_hi;
    assign route_nxt.pin4_lo = wr_pin4_lo ? (wbyte_r & epr_pkg::LO_WR_MASK)
                                          : route_r.pin4_lo;
    assign route_nxt.pin4_hi = wr_pin4_hi ? (wbyte_r & epr_pkg::HI_WR_MASK)
                                          : route_r.pin4_hi;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            // Fuse values, trimmed to the writable bits
            route_r.pin3_hi <= otp_route_dflt.pin3_hi & epr_pkg::HI_WR_MASK;
            route_r.pin4_lo <= otp_route_dflt.pin4_lo & epr_pkg::LO_WR_MASK;
            route_r.pin4_hi <= otp_route_dflt.pin4_hi & epr_pkg::HI_WR_MASK;
        end
        else
        begin
            route_r <= route_nxt;
        end
    end

    // ==========================================================
    // Write handshake
    // Take and fire never meet: ready is low while the item is held
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            aw_held_r <= 1'b0;
            aw_idx_r <= 6'h00;
        end
        else if (aw_take)
        begin
            aw_held_r <= 1'b1;
            aw_idx_r <= addr_idx(s_axil_awaddr);
        end
        else if (wr_fire)
        begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            w_held_r <= 1'b0;
            wbyte_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end
        else if (w_take)
        begin
            w_held_r <= 1'b1;
            wbyte_r <= s_axil_wdata[7:0];
            wstrb0_r <= s_axil_wstrb[0];
        end
        else if (wr_fire)
        begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= epr_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_resp;
        end
        else if (bvalid_r && s_axil_bready)
        begin
            bvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Power-good status
    // Comparator state only; no bus path reaches pg_r
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pg_r <= epr_pkg::PG_RESET;
        end
        else
        begin
            pg_r.buck <= pg_sync.buck;
            pg_r.ldo <= pg_sync.ldo;
        end
    end

    // Loss of regulation is the event; reset value 0 avoids a false one
    wire [7:0] pg_lost = pg_r & ~pg_sync;

    // ==========================================================
    // Read channel
    wire ar_take = s_axil_arvalid && s_axil_arready;
    wire [5:0] rd_idx = addr_idx(s_axil_araddr);
    wire rd_sel_pin3_hi = rd_idx == epr_pkg::IDX_PIN3_HI;
    wire rd_sel_pin4_lo = rd_idx == epr_pkg::IDX_PIN4_LO;
    wire rd_sel_pin4_hi = rd_idx == epr_pkg::IDX_PIN4_HI;
    wire rd_sel_pg = rd_idx == epr_pkg::IDX_PG_STATUS;
    wire rd_sel_evt = rd_idx == epr_pkg::IDX_EVT_STATUS;
    wire rd_sel_mask = rd_idx == epr_pkg::IDX_EVT_MASK;
    wire rd_clr_evt = ar_take && rd_sel_evt;
    wire [7:0] rd_byte = rd_sel_pin3_hi ? route_r.pin3_hi :
                         rd_sel_pin4_lo ? route_r.pin4_lo :
                         rd_sel_pin4_hi ? route_r.pin4_hi :
                         rd_sel_pg ? pg_r :
                         rd_sel_evt ? evt_status :
                         rd_sel_mask ? evt_mask : 8'h00;
    wire [1:0] rd_resp = idx_mapped(rd_idx) ? epr_pkg::RESP_OKAY
                                            : epr_pkg::RESP_SLVERR;

    assign s_axil_arready = !rvalid_r;
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rresp = rresp_r;
    assign s_axil_rdata = {24'h000000, rbyte_r};

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            rvalid_r <= 1'b0;
            rresp_r <= epr_pkg::RESP_OKAY;
            rbyte_r <= 8'h00;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_resp;
            rbyte_r <= rd_byte;
        end
        else if (rvalid_r && s_axil_rready)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Events and interrupt
    epr_evt_bank u_evt (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .evt_set(pg_lost),
        .rd_clr(rd_clr_evt),
        .mask_wr(wr_evt_mask),
        .mask_wdata(wbyte_r),
        .status_r(evt_status),
        .mask_r(evt_mask),
        .irq(evt_irq)
    );

    // ==========================================================
    // Pin-to-regulator control
    // Pin three only reaches bucks and LDO9/10 from this slice
    wire [13:0] route3_vec = hi_vec(route_r.pin3_hi);
    wire [13:0] route4_vec = hi_vec(route_r.pin4_hi) |
                             {4'h0, 2'h0, route_r.pin4_lo};
    wire [13:0] own_vec = route3_vec | route4_vec;
    // A bit at 0 keeps that pin from touching the regulator
    wire [13:0] en_vec = (route3_vec & {14{pin3_sync}}) |
                         (route4_vec & {14{pin4_sync}});

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pin_ctl_r <= '0;
        end
        else
        begin
            pin_ctl_r.buck_own <= own_vec[13:10];
            pin_ctl_r.ldo_own <= own_vec[9:0];
            pin_ctl_r.buck_en <= en_vec[13:10];
            pin_ctl_r.ldo_en <= en_vec[9:0];
        end
    end

    assign pin_ctl = pin_ctl_r;

    // Registered so the pin never shows a decode glitch
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= evt_irq;
        end
    end

    assign irq = irq_r;

    // Protection bits carry no meaning in this slice
    wire unused_prot = ^{s_axil_awprot, s_axil_arprot,
                         s_axil_wdata[31:8], s_axil_wstrb[3:1]};
endmodule
`default_nettype wire

// ### include/epr_pkg.sv
// Purpose: Shared constants and types of the enable-pin routing slice
// Assumes: AXI4-Lite slave, 32-bit data, byte address is four times the index
// Notes: Indices below are kept as printed; only the low byte carries data
package epr_pkg;
    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Register indices
    localparam logic [5:0] IDX_PIN3_HI = 6'h34;
    localparam logic [5:0] IDX_PIN4_LO = 6'h35;
    localparam logic [5:0] IDX_PIN4_HI = 6'h36;
    localparam logic [5:0] IDX_PG_STATUS = 6'h37;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h3C;
    localparam logic [5:0] IDX_EVT_MASK = 6'h3D;
    // ==========================================================
    // Field layout and reset values
    localparam logic [7:0] HI_WR_MASK = 8'h3F;
    localparam logic [7:0] LO_WR_MASK = 8'hFF;
    localparam int HI_LDO9_BIT = 0;
    localparam int HI_LDO10_BIT = 1;
    localparam int HI_BUCK_LSB = 2;
    localparam logic [7:0] PG_RESET = 8'h00;
    localparam logic [7:0] EVT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] pin3_hi;
        logic [7:0] pin4_lo;
        logic [7:0] pin4_hi;
    } epr_route_t;

    typedef struct packed {
        logic [3:0] ldo;
        logic [3:0] buck;
    } epr_pg_t;

    typedef struct packed {
        logic [3:0] buck_own;
        logic [9:0] ldo_own;
        logic [3:0] buck_en;
        logic [9:0] ldo_en;
    } epr_pin_ctl_t;
endpackage

// ### logic/epr_sync.sv
// Purpose: Two-stage synchroniser for pins and comparator levels
// Assumes: Inputs are slow levels, not pulses
// Notes: First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module epr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Levels
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d_async;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ### logic/epr_evt_bank.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Status clears on read; mask bit at 1 blocks that event
// Notes: An event in the clearing cycle is kept
`timescale 1ns/10ps
`default_nettype none
module epr_evt_bank (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Events and software access
    input wire logic [7:0] evt_set,
    input wire logic rd_clr,
    input wire logic mask_wr,
    input wire logic [7:0] mask_wdata,
    // State
    output logic [7:0] status_r,
    output logic [7:0] mask_r,
    output logic irq
);
    logic [7:0] status_nxt;

    // Set wins over the read clear
    assign status_nxt = (status_r & ~{8{rd_clr}}) | evt_set;
    assign irq = |(status_r & ~mask_r);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            status_r <= epr_pkg::EVT_RESET;
            mask_r <= epr_pkg::MASK_RESET;
        end
        else
        begin
            status_r <= status_nxt;
            if (mask_wr)
            begin
                mask_r <= mask_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/epr_chk.sv
// Purpose: Port-level checks of the routing and regulation slice
// Assumes: One clock, synchronous active-low reset
// Notes: Bound from the bench top onto the register slice
`timescale 1ns/10ps
`default_nettype none
module epr_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Read channel
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    // Pins, comparators and control
    input wire logic enable_pin_three,
    input wire logic enable_pin_four,
    input wire logic [3:0] buck_regulation_ok,
    input wire logic [3:0] ldo_regulation_ok,
    input wire epr_pkg::epr_pin_ctl_t pin_ctl,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Helpers
    logic [7:0] ar_q;
    logic [7:0] cmp_q;
    logic [2:0] stab_r;
    wire ar_mapped = (ar_q[7:4] == 4'hD) || (ar_q[7:3] == 5'h1E);
    wire ar_hi = (ar_q[7:2] == epr_pkg::IDX_PIN3_HI) || (ar_q[7:2] == epr_pkg::IDX_PIN4_HI);
    wire ar_pg = s_axil_arvalid && s_axil_arready && s_axil_araddr[7:2] == epr_pkg::IDX_PG_STATUS;
    // Stability count keeps the status check clear of synchroniser lag
    always_ff @(posedge clk_sys)
    begin
        if (s_axil_arvalid && s_axil_arready)
            ar_q <= s_axil_araddr;
        cmp_q <= {ldo_regulation_ok, buck_regulation_ok};
        if (!resetn || cmp_q != {ldo_regulation_ok, buck_regulation_ok})
            stab_r <= 3'h0;
        else if (stab_r != 3'h7)
            stab_r <= stab_r + 3'h1;
    end
    // ==========================================================
    // Assertions
    a_rdata_upper_zero: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h0)
        else $error("Read data upper bits nonzero");
    a_hi_rsvd_zero: assert property (s_axil_rvalid && ar_hi
        |-> s_axil_rdata[7:6] == 2'h0) else $error("Reserved route bits read nonzero");
    a_unmapped_err: assert property (s_axil_rvalid && !ar_mapped
        |-> s_axil_rresp == epr_pkg::RESP_SLVERR && s_axil_rdata == 32'h0)
        else $error("Unmapped read not refused");
    a_rd_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("Read answer late");
    a_en_in_own: assert property ((pin_ctl.buck_en & ~pin_ctl.buck_own) == 4'h0
        && (pin_ctl.ldo_en & ~pin_ctl.ldo_own) == 10'h000) else $error("Unrouted rail enabled");
    a_pins_idle_off: assert property ((!enable_pin_three && !enable_pin_four) [*4]
        |-> pin_ctl.buck_en == 4'h0 && pin_ctl.ldo_en == 10'h000) else $error("Idle pins enable");
    a_pin4_ldo_follow: assert property (enable_pin_four [*4]
        |-> pin_ctl.ldo_en[7:0] == pin_ctl.ldo_own[7:0]) else $error("Pin four route ignored");
    a_pg_follow: assert property (ar_pg && stab_r >= 3'h4
        |=> s_axil_rdata[7:0] == $past(cmp_q)) else $error("Status differs from comparators");
    cover property (s_axil_rvalid && s_axil_rresp == epr_pkg::RESP_SLVERR);
    cover property (enable_pin_four && pin_ctl.ldo_en[7:0] != 8'h00);
    cover property ($rose(irq));
endmodule
`default_nettype wire

// ### test/epr_pwr_model.sv
// Purpose: Regulators behind the slice, reporting regulation
// Assumes: Outputs ramp two cycles after their enable
// Notes: Supplies always above the floor, so status is always valid
`timescale 1ns/10ps
`default_nettype none
module epr_pwr_model (
    // Clock
    input wire logic clk_sys,
    // Enables from the slice
    input wire epr_pkg::epr_pin_ctl_t pin_ctl,
    // Forced loss of regulation, LDO1..4
    input wire logic [3:0] fault_ldo,
    // Comparator levels
    output logic [3:0] buck_ok,
    output logic [3:0] ldo_ok
);
    logic [7:0] ramp_r = 8'h00;
    logic [7:0] ok_r = 8'h00;
    // A disabled or faulted rail never reports good; supply kept valid
    always @(posedge clk_sys)
    begin
        ramp_r <= {pin_ctl.ldo_en[3:0] & ~fault_ldo, pin_ctl.buck_en};
        ok_r <= ramp_r;
    end
    assign {ldo_ok, buck_ok} = ok_r;
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench for the routing and regulation slice
// Assumes: Regulator model on the comparator inputs
// Notes: Bus decisions taken at the falling edge, driven at the rising
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [1:0] rs;
    } epr_row_t;
    localparam logic [1:0] OK = epr_pkg::RESP_OKAY;
    localparam epr_row_t ROWS [5] = '{'{8'hD0, 8'hFF, 8'h3F, OK}, '{8'hD4, 8'hA5, 8'hA5, OK},
        '{8'hD8, 8'hC3, 8'h03, OK}, '{8'hF4, 8'h00, 8'h00, OK},
        '{8'h80, 8'h77, 8'h00, epr_pkg::RESP_SLVERR}};
    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
    logic [2:0] s_axil_awprot = 3'h0, s_axil_arprot = 3'h0;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
    logic s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, irq;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    epr_pkg::epr_route_t otp_route_dflt = 24'hFF5AC1;
    logic enable_pin_three = 1'h0, enable_pin_four = 1'h0;
    logic [3:0] buck_regulation_ok, ldo_regulation_ok, fault_ldo = 4'h0;
    epr_pkg::epr_pin_ctl_t pin_ctl;
    int num_errors = 0, samples_checked = 0;
    epr_regs dut_u (.*);
    epr_pwr_model model_u (.clk_sys(clk_sys), .pin_ctl(pin_ctl), .fault_ldo(fault_ldo),
        .buck_ok(buck_regulation_ok), .ldo_ok(ldo_regulation_ok));
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    // Ready sampled at the falling edge, where it is settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ka, kw, b;
        logic [1:0] r;
        b = 1'h0;
        @(posedge clk_sys);
        s_axil_awaddr <= a;
        s_axil_wdata <= {24'h0, d};
        s_axil_awvalid <= 1'h1;
        s_axil_wvalid <= 1'h1;
        s_axil_bready <= 1'h1;
        while (!b)
        begin
            @(negedge clk_sys);
            ka = s_axil_awready;
            kw = s_axil_wready;
            b = s_axil_bvalid;
            r = s_axil_bresp;
            @(posedge clk_sys);
            if (ka) s_axil_awvalid <= 1'h0;
            if (kw) s_axil_wvalid <= 1'h0;
        end
        s_axil_bready <= 1'h0;
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        logic k, v;
        logic [31:0] d;
        logic [1:0] r;
        v = 1'h0;
        @(posedge clk_sys);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'h1;
        s_axil_rready <= 1'h1;
        while (!v)
        begin
            @(negedge clk_sys);
            k = s_axil_arready;
            v = s_axil_rvalid;
            d = s_axil_rdata;
            r = s_axil_rresp;
            @(posedge clk_sys);
            if (k) s_axil_arvalid <= 1'h0;
        end
        s_axil_rready <= 1'h0;
        chk(d, {24'h0, ed});
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'h1;
        rd(8'hD0, 8'h3F, OK);
        rd(8'hD4, 8'h5A, OK);
        rd(8'hD8, 8'h01, OK);
        rd(8'hDC, 8'h00, OK);
        rd(8'hF4, 8'hFF, OK);
        foreach (ROWS[i])
        begin
            wr(ROWS[i].a, ROWS[i].wd, ROWS[i].rs);
            rd(ROWS[i].a, ROWS[i].rd, ROWS[i].rs);
        end
        s_axil_wstrb <= 4'hE;
        wr(8'hD4, 8'h00, OK);
        s_axil_wstrb <= 4'hF;
        rd(8'hD4, 8'hA5, OK);
        enable_pin_three <= 1'h1;
        settle(10);
        chk({18'h0, pin_ctl.buck_en, pin_ctl.ldo_en}, 32'h3F00);
        chk({18'h0, pin_ctl.buck_own, pin_ctl.ldo_own}, 32'h3FA5);
        rd(8'hDC, 8'h0F, OK);
        enable_pin_three <= 1'h0;
        enable_pin_four <= 1'h1;
        settle(10);
        chk({18'h0, pin_ctl.buck_en, pin_ctl.ldo_en}, 32'h03A5);
        chk({31'h0, irq}, 32'h1);
        rd(8'hDC, 8'h50, OK);
        wr(8'hDC, 8'hFF, OK);
        rd(8'hDC, 8'h50, OK);
        rd(8'hF0, 8'h0F, OK);
        fault_ldo <= 4'h1;
        settle(1);
        chk({31'h0, irq}, 32'h0);
        settle(10);
        chk({31'h0, irq}, 32'h1);
        rd(8'hDC, 8'h40, OK);
        wr(8'hF4, 8'hFF, OK);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        rd(8'hF0, 8'h10, OK);
        resetn <= 1'h0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'h1;
        @(negedge clk_sys);
        chk({3'h0, pin_ctl, irq}, 32'h0);
        rd(8'hD4, 8'h5A, OK);
        rd(8'hD8, 8'h01, OK);
        rd(8'hF4, 8'hFF, OK);
        stop_test();
    end
    initial
    begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        stop_test();
    end
endmodule
bind epr_regs epr_chk chk_u (.*);
`default_nettype wire
